// ==== src/sac_control.sv ====
// sac_control.sv: control logic of a 16-bit successive-approximation converter
// assumes strobes synchronous to clk, comparator decision valid each step
//
// How it works
// - start falling edge with chip select low converts
// - start and read ignored while chip select high
// - bus driven only when read and select low
// - read before select: drive from select edge
// - 16-bit bus, line 15 is msb
// - busy low throughout conversion, high after
// - result present before busy rises
// - further starts ignored until conversion completes
// - trial register cleared at each start
// - bits resolved msb to lsb from comparator
// - final trial word loaded into output latches
// - internal timing sets conversion under maximum
// - result is the final trial word, straight binary
// - shutdown low enters power-down
// - chip select picks nap or sleep
// - nap keeps logic, ready after wake time
// - latches hold previous result during conversion
`include "sac_consts.svh"
`default_nettype none
module sac_control
  import sac_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // host strobes
  input  wire sac_strobe_s strobe,
  // comparator decision: 1 keeps the trial bit
  input  wire logic        comparator_keep,
  // status
  output logic             busy,
  output logic             napping,
  output logic             sleeping,
  // trial word under test, for the dac
  output logic [15:0]      bit_trial_register,
  // result pins
  output sac_bus_s         result_bus
);
  // ****************************************
  // state
  // ****************************************
  sac_state_e      state_q;       // sequencer state
  sac_state_e      state_d;
  logic [7:0]      cnt_q;         // step cycle counter
  logic [7:0]      cnt_d;
  logic [3:0]      bit_q;         // bit under trial
  logic [3:0]      bit_d;
  logic [15:0]     trial_q;       // bit trial register
  logic [15:0]     trial_d;
  logic [15:0]     latch_q;       // output latches
  logic [15:0]     latch_d;
  logic            start_n_q;     // previous start level
  logic            start_n_d;
  logic            busy_q;        // busy pin, active low
  logic            busy_d;
  logic            start_fall;    // qualified start edge

  // one-hot mask for a bit index
  function automatic logic [15:0] bit_mask(input logic [3:0] idx);
    bit_mask = `SAC_RES_W'(1) << idx;
  endfunction : bit_mask

  // ****************************************
  // start detection
  // ****************************************
  // falling edge counts only while selected
  always_comb begin
    start_n_d  = strobe.conversion_start_n;
    start_fall = start_n_q & ~strobe.conversion_start_n
               & ~strobe.chip_select_n;
  end

  // ****************************************
  // sequencer
  // ****************************************
  // next state, counter, trial register and latches
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    bit_d   = bit_q;
    trial_d = trial_q;
    latch_d = latch_q;
    busy_d  = busy_q;
    unique case (state_q)
      SAC_IDLE: begin
        if (!strobe.power_down_n) begin
          // select level picks the kind of shutdown
          state_d = strobe.chip_select_n ? SAC_SLEEP : SAC_NAP;
        end else if (start_fall) begin
          state_d = SAC_CLEAR;
          busy_d  = 1'b0;
        end
      end
      SAC_CLEAR: begin
        // clear before any decision, arm msb
        trial_d = `SAC_MSB_IDX == 4'hF ? bit_mask(`SAC_MSB_IDX)
                                       : `SAC_ZERO16;
        bit_d   = `SAC_MSB_IDX;
        cnt_d   = 8'(`SAC_STEP_CYC - 1);
        state_d = SAC_TRIAL;
      end
      SAC_TRIAL: begin
        // further start edges fall through unseen here
        if (cnt_q != 8'h00) begin
          cnt_d = cnt_q - 8'h01;
        end else begin
          // keep or drop the bit, then try the next lower one
          if (!comparator_keep) begin
            trial_d = trial_q & ~bit_mask(bit_q);
          end
          if (bit_q == 4'h0) begin
            // final word goes to the latches a cycle before busy rises
            latch_d = comparator_keep ? trial_q
                                      : trial_q & ~bit_mask(bit_q);
            state_d = SAC_LOAD;
          end else begin
            bit_d   = bit_q - 4'h1;
            trial_d = (comparator_keep ? trial_q
                                       : trial_q & ~bit_mask(bit_q))
                    | bit_mask(bit_q - 4'h1);
            cnt_d   = 8'(`SAC_STEP_CYC - 1);
          end
        end
      end
      SAC_LOAD: begin
        // latches already hold the word; busy rises after the data
        state_d = SAC_IDLE;
        busy_d  = 1'b1;
      end
      SAC_NAP, SAC_SLEEP: begin
        // starts ignored, latches kept
        if (strobe.power_down_n) begin
          state_d = SAC_WAKE;
          cnt_d   = 8'(`SAC_NAP_CYC - 1);
        end else if (!strobe.chip_select_n) begin
          state_d = SAC_NAP;
        end else begin
          state_d = SAC_SLEEP;
        end
      end
      SAC_WAKE: begin
        // logic stays up in nap; wait the wake time
        if (!strobe.power_down_n) begin
          state_d = strobe.chip_select_n ? SAC_SLEEP : SAC_NAP;
        end else if (cnt_q == 8'h00) begin
          state_d = SAC_IDLE;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: begin
        state_d = SAC_IDLE;
      end
    endcase
  end

  // register all sequencer state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= SAC_IDLE;
      cnt_q     <= 8'h00;
      bit_q     <= 4'h0;
      trial_q   <= `SAC_ZERO16;
      latch_q   <= `SAC_ZERO16;
      start_n_q <= 1'b1;
      busy_q    <= 1'b1;
    end else if (clk_en) begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      bit_q     <= bit_d;
      trial_q   <= trial_d;
      latch_q   <= latch_d;
      start_n_q <= start_n_d;
      busy_q    <= busy_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign busy               = busy_q;
  assign napping            = (state_q == SAC_NAP);
  assign sleeping           = (state_q == SAC_SLEEP);
  assign bit_trial_register = trial_q;

  // three-state result bus
  sac_bus_drive u_bus (
    .clk          (clk),
    .rst          (rst),
    .clk_en       (clk_en),
    .strobe       (strobe),
    .result_latch (latch_q),
    .result_bus   (result_bus)
  );
endmodule : sac_control
`default_nettype wire

// ==== src/sac_consts.svh ====
// sac_consts.svh: timing counts and widths for the converter control block
// assumes a 40 MHz system clock (25 ns period)
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH
// ****************************************
// widths
// ****************************************
`define SAC_RES_W        16
`define SAC_MSB_IDX      4'hF
`define SAC_ZERO16       16'h0000
`define SAC_ONES16       16'hFFFF
// ****************************************
// timing
// ****************************************
`define SAC_CLK_PS       25000
`define SAC_CONV_MAX_PS  1800000
`define SAC_NAP_WAKE_PS  200000
// cycles per bit step: 16 steps plus clear and load must fit the maximum
`define SAC_STEP_CYC     ((`SAC_CONV_MAX_PS / `SAC_CLK_PS) / 18)
// nap wake time rounded up to whole cycles
`define SAC_NAP_CYC      ((`SAC_NAP_WAKE_PS + `SAC_CLK_PS - 1) / `SAC_CLK_PS)
`define SAC_CNT_W        8
`endif

// ==== src/sac_pkg.sv ====
// sac_pkg.sv: types shared by the converter control block
// assumes nothing of its surroundings
`default_nettype none
package sac_pkg;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    SAC_IDLE  = 3'b000,
    SAC_CLEAR = 3'b001,
    SAC_TRIAL = 3'b010,
    SAC_LOAD  = 3'b011,
    SAC_NAP   = 3'b100,
    SAC_SLEEP = 3'b101,
    SAC_WAKE  = 3'b110
  } sac_state_e;

  // host strobes of the parallel port
  typedef struct packed {
    logic chip_select_n;
    logic read_n;
    logic conversion_start_n;
    logic power_down_n;
  } sac_strobe_s;

  // result bus pin group
  typedef struct packed {
    logic [15:0] data_out;
    logic [15:0] data_oe_n;
  } sac_bus_s;
endpackage : sac_pkg
`default_nettype wire

// ==== src/sac_bus_drive.sv ====
// sac_bus_drive.sv: three-state gating of the result bus
// assumes strobes synchronous to clk; oe low means pin driven
`include "sac_consts.svh"
`default_nettype none
module sac_bus_drive
  import sac_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // strobes and latched result
  input  wire sac_strobe_s strobe,
  input  wire logic [15:0] result_latch,
  // pins
  output sac_bus_s         result_bus
);
  // ****************************************
  // output enable
  // ****************************************
  logic en_q;  // bus driven
  logic en_d;

  // enable only while both strobes low; rd first waits for cs edge
  always_comb begin
    en_d = ~strobe.read_n & ~strobe.chip_select_n;
  end

  // register enable
  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= 1'b0;
    end else if (clk_en) begin
      en_q <= en_d;
    end
  end

  // data comes from the output latches, msb on line 15
  assign result_bus.data_out  = result_latch;
  assign result_bus.data_oe_n = {`SAC_RES_W{~en_q}};
endmodule : sac_bus_drive
`default_nettype wire

// ==== test/sac_control_properties.sv ====
// sac_control_properties.sv: assertions on the control block ports
// assumes binding onto sac_control, one clock, sync reset
`default_nettype none
module sac_control_properties
  import sac_pkg::*;
(
  // clock, reset, enable
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        clk_en,
  // pins watched
  input wire sac_strobe_s strobe,
  input wire logic        busy,
  input wire logic        napping,
  input wire logic        sleeping,
  input wire logic [15:0] bit_trial_register,
  input wire sac_bus_s    result_bus
);
  // ****
  // live cycles with busy low
  // ****
  logic [7:0] low_q;
  logic [7:0] low_d;
  always_comb begin
    low_d = busy ? 8'h00 : low_q + {7'h00, clk_en};
  end
  always_ff @(posedge clk) begin
    low_q <= rst ? 8'h00 : low_d;
  end
  // live cycles with shutdown released, saturating at 15
  logic [3:0] awake_q;
  logic [3:0] awake_d;
  always_comb begin
    if (!strobe.power_down_n) begin
      awake_d = 4'h0;
    end else if (awake_q == 4'hF) begin
      awake_d = awake_q;
    end else begin
      awake_d = awake_q + {3'h0, clk_en};
    end
  end
  always_ff @(posedge clk) begin
    awake_q <= rst ? 4'h0 : awake_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_start_taken: assert property (
    $fell(strobe.conversion_start_n) && !strobe.chip_select_n && clk_en
    && strobe.power_down_n && awake_q >= 4'hA && busy
    |=> !busy) else $error("start not taken");
  chk_start_refused: assert property (
    busy && (strobe.chip_select_n || !strobe.power_down_n) |=> busy)
    else $error("start taken while refused");
  chk_busy_len: assert property (
    $rose(busy) |-> low_q == 8'h42) else $error("busy width wrong");
  chk_msb_first: assert property (
    $fell(busy) |=> bit_trial_register == 16'h8000)
    else $error("trial word not cleared to msb");
  chk_load_end: assert property (
    $changed(result_bus.data_out) |-> !busy ##1 busy)
    else $error("result changed outside load");
  chk_oe_on: assert property (
    clk_en && !strobe.read_n && !strobe.chip_select_n
    |=> result_bus.data_oe_n == 16'h0000) else $error("bus not driven");
  chk_oe_off: assert property (
    clk_en && (strobe.read_n || strobe.chip_select_n)
    |=> result_bus.data_oe_n == 16'hFFFF) else $error("bus not released");
  chk_shut_enter: assert property (
    busy && !strobe.power_down_n && clk_en |=> napping || sleeping)
    else $error("no power-down");
  chk_mode_pick: assert property (
    (napping || sleeping) && !strobe.power_down_n && clk_en |=>
    sleeping == $past(strobe.chip_select_n) && napping != sleeping)
    else $error("wrong power-down mode");
  chk_wake_hold: assert property (
    $fell(napping) |-> busy [*8]) else $error("start during wake");
endmodule : sac_control_properties
bind sac_control sac_control_properties sac_control_properties_inst (
  .clk(clk), .rst(rst), .clk_en(clk_en), .strobe(strobe), .busy(busy),
  .napping(napping), .sleeping(sleeping),
  .bit_trial_register(bit_trial_register), .result_bus(result_bus));
`default_nettype wire

// ==== test/sac_host_model.sv ====
// sac_host_model.sv: host processor and analog stand-in for the block
// assumes strobes are sampled on the rising clk edge
`default_nettype none
module sac_host_model
  import sac_pkg::*;
#(
  parameter int WAKE_CYC = 12 // wait after shutdown, scaled down
)(
  // clock and block pins
  input  wire logic        clk,
  input  wire logic [15:0] bit_trial_register,
  output var sac_strobe_s  strobe,
  output logic             comparator_keep
);
  logic [15:0] target = 16'h0000; // level the input sits at
  // keep a trial bit while the trial word stays at or under target
  assign comparator_keep = bit_trial_register <= target;
  initial strobe = '1;
  // one strobe change just after an edge
  task automatic drive(input sac_strobe_s s);
    @(posedge clk);
    strobe <= s;
  endtask : drive
  // acquisition wait, then a short start pulse with select low
  task automatic start(input logic [15:0] v);
    target <= v;
    repeat (20) @(posedge clk);
    drive('{1'b0, 1'b1, 1'b0, 1'b1});
    drive('{1'b0, 1'b1, 1'b0, 1'b1});
    drive('1);
  endtask : start
  // leave shutdown and let the reference settle
  task automatic wake();
    drive('1);
    repeat (WAKE_CYC) @(posedge clk);
  endtask : wake
endmodule : sac_host_model
`default_nettype wire

// ==== test/sac_control_tb.sv ====
// sac_control_tb.sv: self-checking bench for the control block
// assumes the package, host model and checker are compiled first
`default_nettype none
module sac_control_tb
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  sac_strobe_s strobe;
  logic        keep;
  logic        busy;
  logic        napping;
  logic        sleeping;
  logic [15:0] trial;
  sac_bus_s    bus;
  logic [15:0] last = 16'h0000; // previous result word
  int          err_total = 0;
  int          tests_run = 0;
  initial forever #12.5 clk = ~clk;
  sac_control sac_control_inst (.clk(clk), .rst(rst), .clk_en(1'b1),
    .strobe(strobe), .comparator_keep(keep), .busy(busy),
    .napping(napping), .sleeping(sleeping),
    .bit_trial_register(trial), .result_bus(bus));
  sac_host_model sac_host_model_inst (.clk(clk), .strobe(strobe),
    .bit_trial_register(trial), .comparator_keep(keep));
  task automatic chk(input string n, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic t_conv(input logic [15:0] v, input bit poke);
    int n;
    n = 0;
    sac_host_model_inst.start(v);
    while (busy !== 1'b0 && n < 9) begin
      tick(1);
      n++;
    end
    if (poke) begin
      chk("held", last, bus.data_out);
      sac_host_model_inst.start(v);
    end
    while (busy !== 1'b1 && n < 99) begin
      tick(1);
      n++;
    end
    chk("result", v, bus.data_out);
    sac_host_model_inst.drive('{1'b0, 1'b0, 1'b1, 1'b1});
    tick(1);
    chk("read", v, bus.data_out & ~bus.data_oe_n);
    sac_host_model_inst.drive('1);
    tick(1);
    chk("oe_off", 16'hFFFF, bus.data_oe_n);
    last = v;
    $display("test conv %h done", v);
  endtask : t_conv
  task automatic t_refuse();
    sac_host_model_inst.drive('{1'b1, 1'b0, 1'b0, 1'b1});
    tick(3);
    chk("busy", 16'h0001, {15'h0000, busy});
    chk("oe_cs", 16'hFFFF, bus.data_oe_n);
    sac_host_model_inst.drive('{1'b0, 1'b0, 1'b0, 1'b1});
    tick(1);
    chk("oe_late", 16'h0000, bus.data_oe_n);
    chk("no_edge", 16'h0001, {15'h0000, busy});
    sac_host_model_inst.drive('1);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_shut(input logic cs);
    sac_host_model_inst.drive('{cs, 1'b1, 1'b1, 1'b0});
    tick(2);
    chk("mode", {14'h0000, ~cs, cs}, {14'h0000, napping, sleeping});
    sac_host_model_inst.drive('{1'b0, 1'b1, 1'b0, 1'b0});
    tick(2);
    chk("shut", 16'h0001, {15'h0000, busy});
    sac_host_model_inst.wake();
    $display("test shut %b done", cs);
  endtask : t_shut
  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk("reset_oe", 16'hFFFF, bus.data_oe_n);
    chk("reset_data", 16'h0000, bus.data_out);
    t_conv(16'h7FFF, 1'b0);
    t_conv(16'h8000, 1'b1);
    t_conv(16'hFFFF, 1'b0);
    t_refuse();
    t_shut(1'b0);
    t_conv(16'h0000, 1'b0);
    t_shut(1'b1);
    t_conv(16'h1234, 1'b1);
    finish_test();
  end
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    finish_test();
  end
endmodule : sac_control_tb
`default_nettype wire
